// ==== rtl/cs_card_cmd.v ====
`timescale 1ns/1ps
// Notes on behaviour
// - inapplicable command: ignored, no state change, silent
// - illegal command: stay, reply with bit 22
// - ready plus CMD2: win to naming, lose stays
// - addressed CMD7: standby to transfer, parked to programming
// - unaddressed CMD7: transfer/sending to standby, programming parks
// - replies go out serially, MSB first
// - short reply: 0,0,index,status,CRC7,1
// - busy variant identical to short reply
// - long reply: 0,0,reserved,bits 127..1,end bit
// - identity register answers CMD2 and CMD10
// - card-specific data answers CMD9
// - voltage reply: 0,0,reserved,voltage field,reserved,1
// - voltage field fixed; busy clears top bit
// - local 32-bit status sent in short replies
// - response-detected bits set for current reply
// - clear by class: state, next command, read
// - bits 12:9 carry current state code
// - bit 22 illegal, bit 23 command CRC fail
`include "cs_card_cmd_regs.vh"

module cs_card_cmd #(
  parameter AW = 8
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire [AW-1:0] s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [AW-1:0] s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  input  wire          link_clk,
  input  wire          cmd_in,
  output reg           cmd_out,
  output reg           cmd_oe,
  output reg           irq
);

  localparam PH_RX   = 2'h0;
  localparam PH_EXE  = 2'h1;
  localparam PH_WAIT = 2'h2;
  localparam PH_TX   = 2'h3;

  function [6:0] crc7_40;
    input [39:0] d;
    integer i;
    reg [6:0] c;
    reg       fb;
    begin
      c = 7'h00;
      for (i = 39; i >= 0; i = i - 1) begin
        fb = d[i] ^ c[6];
        c  = {c[5:0], 1'b0} ^ (fb ? `CS_CRC_POLY : 7'h00);
      end
      crc7_40 = c;
    end
  endfunction

  // {kind, next state} from index and present state
  function [5:0] cs_step;
    input [5:0] ix;
    input [3:0] s;
    input       addr;
    input       compat;
    input       busy;
    reg [1:0] k;
    reg [3:0] n;
    reg       drp;
    begin
      k   = `CS_K_IGN;
      n   = s;
      drp = (s == `CS_S_DATA) || (s == `CS_S_RCV) || (s == `CS_S_PRG);
      case (ix)
        6'd0: if (s != `CS_S_INA) begin
          k = `CS_K_OK;
          n = `CS_S_IDLE;
        end
        6'd1: if (s == `CS_S_IDLE) begin
          k = `CS_K_OK;
          n = !compat ? `CS_S_INA : (busy ? `CS_S_IDLE : `CS_S_READY);
        end
        6'd2: if (s == `CS_S_READY) begin
          k = `CS_K_OK;
          n = `CS_S_IDENT;
        end
        6'd3: if (s == `CS_S_IDENT) begin
          k = `CS_K_OK;
          n = `CS_S_STBY;
        end
        6'd4, 6'd9, 6'd10: if (s == `CS_S_STBY) k = `CS_K_OK;
        6'd7: if (addr) begin
          if (s == `CS_S_STBY) begin
            k = `CS_K_OK;
            n = `CS_S_TRAN;
          end else if (s == `CS_S_DIS) begin
            k = `CS_K_OK;
            n = `CS_S_PRG;
          end else if (drp || s == `CS_S_TRAN) begin
            k = `CS_K_ILL;
          end
        end else begin
          if (s == `CS_S_TRAN || s == `CS_S_DATA) begin
            k = `CS_K_OK;
            n = `CS_S_STBY;
          end else if (s == `CS_S_PRG) begin
            k = `CS_K_OK;
            n = `CS_S_DIS;
          end
        end
        6'd12: begin
          if (s == `CS_S_DATA) begin
            k = `CS_K_OK;
            n = `CS_S_TRAN;
          end else if (s == `CS_S_RCV) begin
            k = `CS_K_OK;
            n = `CS_S_PRG;
          end else if (s == `CS_S_TRAN || s == `CS_S_PRG || s == `CS_S_DIS) begin
            k = `CS_K_ILL;
          end
        end
        6'd13: if (s >= `CS_S_STBY && s <= `CS_S_DIS) k = `CS_K_OK;
        6'd15: if (s >= `CS_S_STBY && s <= `CS_S_DIS) begin
          k = `CS_K_OK;
          n = `CS_S_INA;
        end
        6'd11, 6'd20, 6'd42: if (s == `CS_S_TRAN) begin
          k = `CS_K_OK;
          n = (ix == 6'd11) ? `CS_S_DATA : `CS_S_RCV;
        end
        6'd24, 6'd25: if (s == `CS_S_TRAN || s == `CS_S_PRG) begin
          k = `CS_K_OK;
          n = `CS_S_RCV;
        end else if (drp) begin
          k = `CS_K_ILL;
        end
        6'd16, 6'd17, 6'd18, 6'd26, 6'd27, 6'd28, 6'd29, 6'd30,
        6'd32, 6'd33, 6'd34, 6'd35, 6'd36, 6'd37, 6'd38: begin
          if (s == `CS_S_TRAN) begin
            k = `CS_K_OK;
            case (ix)
              6'd17, 6'd18, 6'd30:        n = `CS_S_DATA;
              6'd26, 6'd27:               n = `CS_S_RCV;
              6'd28, 6'd29, 6'd38:        n = `CS_S_PRG;
              default:                    n = `CS_S_TRAN;
            endcase
          end else if (drp) begin
            k = `CS_K_ILL;
          end
        end
        default: k = `CS_K_IGN;
      endcase
      cs_step = {k, n};
    end
  endfunction

  // reply kind for a legal command
  function [2:0] cs_reply;
    input [5:0] ix;
    input [3:0] n;
    begin
      case (ix)
        6'd0, 6'd4, 6'd15: cs_reply = `CS_RP_NONE;
        6'd1:  cs_reply = (n == `CS_S_INA) ? `CS_RP_NONE : `CS_RP_VOLT;
        6'd2, 6'd10: cs_reply = `CS_RP_CID;
        6'd9:  cs_reply = `CS_RP_CSD;
        default: cs_reply = `CS_RP_SHORT;
      endcase
    end
  endfunction

  function [31:0] strb_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer b;
    begin
      strb_merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (st[b]) strb_merge[b*8 +: 8] = nw[b*8 +: 8];
    end
  endfunction

  // software-visible state
  reg  [2:0]  ctrl;
  reg  [31:0] id_mem [0:7];
  reg  [`CS_EV_W-1:0] int_status;
  reg  [`CS_EV_W-1:0] int_mask;
  reg         inj_pulse;
  reg  [31:0] inj_data;

  // link side
  reg         lk_s1, lk_s2, lk_s3;
  reg         cd_s1, cd_s2;
  reg  [1:0]  ph;
  reg  [7:0]  bcnt;
  reg  [7:0]  tx_len;
  reg  [47:0] rx_sh;
  reg  [135:0] tx_sh;
  reg         arb;
  reg         cur_bit;
  reg  [3:0]  card_state;
  reg  [15:0] rca;
  reg  [31:0] err_c;
  reg         crc_f;
  reg  [5:0]  last_ix;
  reg  [31:0] last_arg;
  reg  [`CS_EV_W-1:0] ev;

  wire        rise = lk_s2 & ~lk_s3;
  wire        fall = ~lk_s2 & lk_s3;
  wire [5:0]  f_ix  = rx_sh[45:40];
  wire [31:0] f_arg = rx_sh[39:8];
  wire        f_ok  = rx_sh[46] & rx_sh[0] & (crc7_40(rx_sh[47:8]) == rx_sh[7:1]);
  wire        compat = (f_arg == 32'h0) || ((f_arg & `CS_VOLT_READY) != 32'h0);
  wire        busy   = ~ctrl[`CS_CTRL_PWRUP];
  wire [5:0]  step   = cs_step(f_ix, card_state, f_arg[31:16] == rca, compat, busy);
  wire [1:0]  kind   = step[5:4];
  wire [3:0]  nstate = step[3:0];
  wire [2:0]  rkind  = (kind == `CS_K_ILL) ? `CS_RP_SHORT : cs_reply(f_ix, nstate);
  wire [127:0] card_identity_reg   = {id_mem[0], id_mem[1], id_mem[2], id_mem[3]};
  wire [127:0] card_specific_data_reg   = {id_mem[4], id_mem[5], id_mem[6], id_mem[7]};
  wire [31:0] operating_voltage_reg    = busy ? `CS_VOLT_BUSY : `CS_VOLT_READY;

  // status as sent: class-B flags for this reply, state before the command
  wire [31:0] stat_now = (err_c & `CS_ST_CLR_READ)
                       | ({31'h0, ctrl[`CS_CTRL_LOCKED]} << `CS_ST_LOCKED)
                       | ({31'h0, crc_f} << `CS_ST_CRC)
                       | ({31'h0, kind == `CS_K_ILL} << `CS_ST_ILL)
                       | ({31'h0, ctrl[`CS_CTRL_ECCDIS]} << `CS_ST_ECCDIS)
                       | ({28'h0, card_state} << `CS_ST_STATE_LO);
  wire [39:0] sh_head = {2'b00, f_ix, stat_now};

  // live view for software, no flags pending from a command
  wire [31:0] stat_view = (err_c & `CS_ST_CLR_READ)
                        | ({31'h0, ctrl[`CS_CTRL_LOCKED]} << `CS_ST_LOCKED)
                        | ({31'h0, crc_f} << `CS_ST_CRC)
                        | ({31'h0, ctrl[`CS_CTRL_ECCDIS]} << `CS_ST_ECCDIS)
                        | ({28'h0, card_state} << `CS_ST_STATE_LO);

  always @(posedge aclk) begin
    if (!aresetn) begin
      lk_s1      <= 1'b0;
      lk_s2      <= 1'b0;
      lk_s3      <= 1'b0;
      cd_s1      <= 1'b1;
      cd_s2      <= 1'b1;
      ph         <= PH_RX;
      bcnt       <= 8'h00;
      tx_len     <= 8'h00;
      rx_sh      <= 48'h0;
      tx_sh      <= 136'h0;
      arb        <= 1'b0;
      cur_bit    <= 1'b1;
      card_state <= `CS_S_IDLE;
      rca        <= `CS_RCA_RST;
      err_c      <= 32'h0;
      crc_f      <= 1'b0;
      last_ix    <= 6'h00;
      last_arg   <= 32'h0;
      ev         <= {`CS_EV_W{1'b0}};
      cmd_out    <= 1'b1;
      cmd_oe     <= 1'b0;
    end else begin
      lk_s1 <= link_clk;
      lk_s2 <= lk_s1;
      lk_s3 <= lk_s2;
      cd_s1 <= cmd_in;
      cd_s2 <= cd_s1;
      ev    <= {`CS_EV_W{1'b0}};
      if (inj_pulse)
        err_c <= err_c | (inj_data & `CS_ST_CLR_READ);
      case (ph)
        PH_RX: if (rise) begin
          if (bcnt != 8'h00 || !cd_s2) begin
            rx_sh <= {rx_sh[46:0], cd_s2};
            bcnt  <= (bcnt == `CS_LEN_SHORT - 8'h01) ? 8'h00 : bcnt + 8'h01;
            if (bcnt == `CS_LEN_SHORT - 8'h01)
              ph <= PH_EXE;
          end
        end
        PH_EXE: begin
          ph <= PH_RX;
          if (!f_ok) begin
            crc_f        <= 1'b1;
            ev[`CS_EV_CRC] <= 1'b1;
          end else if (kind != `CS_K_IGN) begin
            ev[`CS_EV_CMD] <= 1'b1;
            ev[`CS_EV_ILL] <= (kind == `CS_K_ILL);
            last_ix  <= f_ix;
            last_arg <= f_arg;
            crc_f    <= 1'b0;
            if (kind == `CS_K_OK)
              card_state <= nstate;
            if (kind == `CS_K_OK && f_ix == 6'd3)
              rca <= f_arg[31:16];
            arb <= (kind == `CS_K_OK) && (f_ix == 6'd2);
            case (rkind)
              `CS_RP_SHORT: begin
                tx_sh  <= {sh_head, crc7_40(sh_head), 1'b1, 88'h0};
                tx_len <= `CS_LEN_SHORT;
                err_c  <= inj_pulse ? (inj_data & `CS_ST_CLR_READ) : 32'h0;
              end
              `CS_RP_CID: begin
                tx_sh  <= {2'b00, 6'h3f, card_identity_reg[127:1], 1'b1};
                tx_len <= `CS_LEN_LONG;
              end
              `CS_RP_CSD: begin
                tx_sh  <= {2'b00, 6'h3f, card_specific_data_reg[127:1], 1'b1};
                tx_len <= `CS_LEN_LONG;
              end
              `CS_RP_VOLT: begin
                tx_sh  <= {2'b00, 6'h3f, operating_voltage_reg, 7'h7f, 1'b1, 88'h0};
                tx_len <= `CS_LEN_SHORT;
              end
              default: tx_len <= 8'h00;
            endcase
            if (rkind != `CS_RP_NONE)
              ph <= PH_WAIT;
          end
        end
        PH_WAIT: if (fall) begin
          // gap before the reply, counted in link clocks
          if (bcnt == `CS_NCR - 8'h01) begin
            ph      <= PH_TX;
            bcnt    <= 8'h01;
            cur_bit <= tx_sh[135];
            cmd_out <= tx_sh[135];
            cmd_oe  <= arb ? ~tx_sh[135] : 1'b1;
            tx_sh   <= {tx_sh[134:0], 1'b0};
          end else begin
            bcnt <= bcnt + 8'h01;
          end
        end
        PH_TX: begin
          if (rise && arb && cur_bit && !cd_s2) begin
            // another card pulled the line low: lost arbitration
            card_state     <= `CS_S_READY;
            cmd_oe         <= 1'b0;
            cmd_out        <= 1'b1;
            ph             <= PH_RX;
            bcnt           <= 8'h00;
            arb            <= 1'b0;
            ev[`CS_EV_ARB] <= 1'b1;
          end else if (fall) begin
            if (bcnt == tx_len) begin
              cmd_oe          <= 1'b0;
              cmd_out         <= 1'b1;
              ph              <= PH_RX;
              bcnt            <= 8'h00;
              arb             <= 1'b0;
              ev[`CS_EV_DONE] <= 1'b1;
            end else begin
              bcnt    <= bcnt + 8'h01;
              cur_bit <= tx_sh[135];
              cmd_out <= tx_sh[135];
              cmd_oe  <= arb ? ~tx_sh[135] : 1'b1;
              tx_sh   <= {tx_sh[134:0], 1'b0};
            end
          end
        end
        default: ph <= PH_RX;
      endcase
    end
  end

  // register bus
  reg [AW-1:0] aw_addr;
  reg          aw_full;
  reg [31:0]   w_data;
  reg [3:0]    w_strb;
  reg          w_full;
  integer      k;
  wire         aw_id = (aw_addr >= `CS_ID_BASE) && (aw_addr <= `CS_ID_LAST);
  wire         ar_id = (s_axi_araddr >= `CS_ID_BASE) && (s_axi_araddr <= `CS_ID_LAST);
  wire [2:0]   aw_ix = aw_addr[4:2];
  wire [2:0]   ar_ix = s_axi_araddr[4:2];
  wire [31:0]  ctrl_wr = strb_merge({29'h0, ctrl}, w_data, w_strb);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'b00;
      s_axi_rdata   <= 32'h0;
      aw_addr       <= {AW{1'b0}};
      aw_full       <= 1'b0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      w_full        <= 1'b0;
      ctrl          <= `CS_CTRL_RST;
      int_status    <= {`CS_EV_W{1'b0}};
      int_mask      <= {`CS_EV_W{1'b0}};
      inj_pulse     <= 1'b0;
      inj_data      <= 32'h0;
      irq           <= 1'b0;
      for (k = 0; k < 8; k = k + 1)
        id_mem[k] <= 32'h0;
    end else begin
      inj_pulse <= 1'b0;
      irq       <= |(int_status & int_mask);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_full       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_full       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      // set wins over the write-one clear
      int_status <= int_status | ev;
      if (aw_full && w_full && !s_axi_bvalid) begin
        aw_full       <= 1'b0;
        w_full        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= 2'b00;
        if (aw_id) begin
          id_mem[aw_ix] <= strb_merge(id_mem[aw_ix], w_data, w_strb);
        end else begin
          case (aw_addr)
            `CS_CTRL:       ctrl <= ctrl_wr[2:0];
            `CS_INJECT: begin
              inj_pulse <= 1'b1;
              inj_data  <= strb_merge(32'h0, w_data, w_strb);
            end
            `CS_INT_STATUS: int_status <= (int_status & ~w_data[`CS_EV_W-1:0]) | ev;
            `CS_INT_MASK:   int_mask <= w_data[`CS_EV_W-1:0];
            `CS_STATUS, `CS_STATE, `CS_LAST_IX, `CS_LAST_ARG: s_axi_bresp <= 2'b00;
            default:        s_axi_bresp <= 2'b10;
          endcase
        end
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= 2'b00;
        if (ar_id) begin
          s_axi_rdata <= id_mem[ar_ix];
        end else begin
          case (s_axi_araddr)
            `CS_CTRL:       s_axi_rdata <= {29'h0, ctrl};
            `CS_STATUS:     s_axi_rdata <= stat_view;
            `CS_STATE:      s_axi_rdata <= {rca, 12'h0, card_state};
            `CS_LAST_IX:    s_axi_rdata <= {26'h0, last_ix};
            `CS_LAST_ARG:   s_axi_rdata <= last_arg;
            `CS_INT_STATUS: s_axi_rdata <= {27'h0, int_status};
            `CS_INT_MASK:   s_axi_rdata <= {27'h0, int_mask};
            `CS_INJECT:     s_axi_rdata <= 32'h0;
            default: begin
              s_axi_rdata <= 32'h0;
              s_axi_rresp <= 2'b10;
            end
          endcase
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// ==== include/cs_card_cmd_regs.vh ====
`ifndef CS_CARD_CMD_REGS_VH
`define CS_CARD_CMD_REGS_VH

// register byte offsets
`define CS_CTRL        8'h00
`define CS_INJECT      8'h04
`define CS_STATUS      8'h08
`define CS_STATE       8'h0c
`define CS_LAST_IX     8'h10
`define CS_LAST_ARG    8'h14
`define CS_INT_STATUS  8'h18
`define CS_INT_MASK    8'h1c
`define CS_ID_BASE     8'h20
`define CS_ID_LAST     8'h3c

// control fields
`define CS_CTRL_PWRUP  0
`define CS_CTRL_LOCKED 1
`define CS_CTRL_ECCDIS 2
`define CS_CTRL_RST    3'h0

// interrupt event bits
`define CS_EV_CMD      0
`define CS_EV_ILL      1
`define CS_EV_CRC      2
`define CS_EV_DONE     3
`define CS_EV_ARB      4
`define CS_EV_W        5

// card status fields
`define CS_ST_CRC      23
`define CS_ST_ILL      22
`define CS_ST_LOCKED   25
`define CS_ST_ECCDIS   14
`define CS_ST_STATE_LO 9
`define CS_ST_CLR_READ 32'hfd3fa000

// card states
`define CS_S_IDLE      4'h0
`define CS_S_READY     4'h1
`define CS_S_IDENT     4'h2
`define CS_S_STBY      4'h3
`define CS_S_TRAN      4'h4
`define CS_S_DATA      4'h5
`define CS_S_RCV       4'h6
`define CS_S_PRG       4'h7
`define CS_S_DIS       4'h8
`define CS_S_INA       4'h9

// step outcome
`define CS_K_IGN       2'h0
`define CS_K_OK        2'h1
`define CS_K_ILL       2'h2

// reply kinds
`define CS_RP_NONE     3'h0
`define CS_RP_SHORT    3'h1
`define CS_RP_CID      3'h2
`define CS_RP_CSD      3'h3
`define CS_RP_VOLT     3'h4

// frame constants
`define CS_VOLT_READY  32'h80ff8000
`define CS_VOLT_BUSY   32'h00ff8000
`define CS_CRC_POLY    7'h09
`define CS_LEN_SHORT   8'h30
`define CS_LEN_LONG    8'h88
`define CS_NCR         8'h02
`define CS_RCA_RST     16'h0001

`endif

// ==== verif/cs_card_cmd_sva.sv ====
`timescale 1ns/1ps
module cs_card_cmd_sva (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        link_clk,
  input wire        cmd_out,
  input wire        cmd_oe
);
  logic       lk_d;
  logic [3:0] fall_age;
  // age since a raw link fall; saturates so a stalled link never wraps
  always @(posedge aclk) begin
    lk_d <= link_clk;
    if (!aresetn)
      fall_age <= 4'hf;
    else if (lk_d && !link_clk)
      fall_age <= 4'h0;
    else if (fall_age != 4'hf)
      fall_age <= fall_age + 4'h1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  idle_line_a: assert property (!cmd_oe |-> cmd_out)
    else $error("released line not high");
  start_bit_a: assert property ($rose(cmd_oe) |-> !cmd_out)
    else $error("reply start bit not low");
  bit_timing_a: assert property ($changed(cmd_out) || $changed(cmd_oe) |-> fall_age < 4'h7)
    else $error("reply bit moved away from link fall");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  refuse_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  write_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready ##1 s_axi_bvalid)
    else $error("write answer late");
endmodule
bind cs_card_cmd cs_card_cmd_sva cs_card_cmd_sva_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .link_clk(link_clk), .cmd_out(cmd_out), .cmd_oe(cmd_oe));

// ==== verif/cs_host_model.sv ====
`timescale 1ns/1ps
module cs_host_model (
  input  wire logic        go,
  input  wire logic [5:0]  idx,
  input  wire logic [31:0] arg,
  input  wire logic        bad,
  input  wire logic        clash,
  input  wire logic [7:0]  rmax,
  input  wire logic        line,
  output logic             link_clk,
  output logic             drv_n,
  output logic             done,
  output logic [7:0]       rlen,
  output logic [135:0]     resp
);
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--)
      c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
    return c;
  endfunction
  task automatic tick();
    #24 link_clk = 1'b1;
    #24 link_clk = 1'b0;
  endtask
  initial begin
    link_clk = 1'b0;
    drv_n = 1'b1;
    done = 1'b0;
    rlen = 8'h00;
    resp = '0;
  end
  // clock stands still between frames; odd offset keeps link edges off aclk edges
  always @(posedge go) begin : frame
    logic [47:0] f;
    int          w;
    f = {2'b01, idx, arg, 8'h01};
    f[7:1] = crc7(f[47:8]) ^ {6'h00, bad};
    #1.3;
    for (int n = 47; n >= 0; n--) begin
      drv_n = f[n];
      tick();
    end
    drv_n = 1'b1;
    rlen = 8'h00;
    resp = '0;
    w = 0;
    while (rlen < rmax && w < 24) begin
      #24 link_clk = 1'b1;
      if (rlen != 8'h00 || !line) begin
        resp = {resp[134:0], line};
        rlen = rlen + 8'h01;
      end else
        w++;
      #24 link_clk = 1'b0;
      drv_n = !(clash && rlen == 8'h02);
    end
    repeat (3) tick();
    done = 1'b1;
    #5 done = 1'b0;
  end
endmodule

// ==== verif/cs_card_cmd_bench.sv ====
`timescale 1ns/1ps
`include "cs_card_cmd_regs.vh"
`define CHK(a, e) begin exp_v = (e); cmp_count++; if ((a) !== exp_v) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), exp_v); end end
module cs_card_cmd_bench;
  logic         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go, bad, clash;
  logic         awready, wready, bvalid, arready, rvalid, cmd_out, cmd_oe, irq;
  logic         link_clk, drv_n, done;
  logic [1:0]   bresp, rresp;
  logic [5:0]   idx;
  logic [7:0]   awaddr, araddr, rmax, rlen;
  logic [31:0]  wdata, rdata, arg, seed;
  logic [127:0] card_identity_reg, card_specific_data_reg;
  logic [135:0] resp;
  logic [143:0] exp_v, rq[$];
  logic [33:0]  aq[$];
  int           errors, cmp_count;
  logic [31:0]  rca_arg = 32'h1234_0000;
  // pull-up on the command line; either party only pulls low or releases
  wire          line = !((cmd_oe && !cmd_out) || !drv_n);
  cs_card_cmd cs_card_cmd_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .link_clk(link_clk), .cmd_in(line), .cmd_out(cmd_out),
    .cmd_oe(cmd_oe), .irq(irq));
  cs_host_model host_inst (.go(go), .idx(idx), .arg(arg), .bad(bad), .rmax(rmax), .line(line),
    .clash(clash), .link_clk(link_clk), .drv_n(drv_n), .done(done), .rlen(rlen), .resp(resp));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [143:0] sh(input logic [5:0] i, input logic [3:0] st,
                                      input logic [31:0] fl);
    logic [39:0] d;
    d = {2'b00, i, fl | {19'h0, st, 9'h0}};
    return {`CS_LEN_SHORT, 88'h0, d, host_inst.crc7(d), 1'b1};
  endfunction
  function automatic logic [143:0] lg(input logic [127:0] r);
    return {`CS_LEN_LONG, 8'h3f, r[127:1], 1'b1};
  endfunction
  function automatic logic [143:0] volt(input logic [31:0] v);
    return {`CS_LEN_SHORT, 88'h0, 8'h3f, v, 8'hff};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    aq.push_back({e, 32'h0});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid === 1'b1 && bready === 1'b1) break;
      if (bvalid === 1'b1) bready <= 1'b1;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    aq.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid === 1'b1 && rready === 1'b1) break;
      if (rvalid === 1'b1) rready <= 1'b1;
    end
    rready <= 1'b0;
  endtask
  task automatic cmd(input logic [5:0] i, input logic [31:0] a, input logic b,
                     input logic [143:0] e);
    rq.push_back(e);
    @(posedge aclk);
    idx <= i;
    arg <= a;
    bad <= b;
    rmax <= (e[143:136] == `CS_LEN_LONG) ? `CS_LEN_LONG : `CS_LEN_SHORT;
    go <= 1'b1;
    @(posedge done);
    @(posedge aclk);
    go <= 1'b0;
  endtask
  task automatic complete_run();
    if (errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge done) `CHK({rlen, resp}, rq.pop_front())
  always @(posedge aclk) begin
    if (bvalid && bready) `CHK({bresp, 32'h0}, aq.pop_front())
    if (rvalid && rready) `CHK({rresp, rdata}, aq.pop_front())
  end
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    #400000;
    errors++;
    complete_run();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, go, bad, clash} = '0;
    {awaddr, araddr, wdata, idx, arg, rmax} = '0;
    seed = 32'hc373a05b;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      card_identity_reg[127-32*k -: 32] = xs();
      card_specific_data_reg[127-32*k -: 32] = xs();
      wr(`CS_ID_BASE + 8'(4*k), card_identity_reg[127-32*k -: 32], 2'b00);
      wr(`CS_ID_BASE + 8'(16+4*k), card_specific_data_reg[127-32*k -: 32], 2'b00);
    end
    wr(`CS_INT_MASK, 32'h4, 2'b00);
    rd(`CS_STATE, {2'b00, 32'h0001_0000});
    rd(8'h40, {2'b10, 32'h0});
    wr(8'h40, 32'h1, 2'b10);
    cmd(6'h0d, 32'h0, 1'b0, 144'h0);
    cmd(6'h01, 32'h0, 1'b0, volt(`CS_VOLT_BUSY));
    wr(`CS_CTRL, 32'h1, 2'b00);
    cmd(6'h01, 32'h0, 1'b0, volt(`CS_VOLT_READY));
    cmd(6'h07, 32'h0001_0000, 1'b0, 144'h0);
    // another card holds the line low over the first reserved bit
    clash <= 1'b1;
    cmd(6'h02, 32'h0, 1'b0, {`CS_LEN_LONG, 3'b000, {133{1'b1}}});
    clash <= 1'b0;
    rd(`CS_STATE, {2'b00, 32'h0001_0001});
    cmd(6'h02, 32'h0, 1'b0, lg(card_identity_reg));
    cmd(6'h03, rca_arg, 1'b0, sh(6'h03, `CS_S_IDENT, 32'h0));
    rd(`CS_STATE, {2'b00, 32'h1234_0003});
    cmd(6'h09, rca_arg, 1'b0, lg(card_specific_data_reg));
    cmd(6'h0a, rca_arg, 1'b0, lg(card_identity_reg));
    cmd(6'h07, rca_arg, 1'b0, sh(6'h07, `CS_S_STBY, 32'h0));
    cmd(6'h07, rca_arg, 1'b0, sh(6'h07, `CS_S_TRAN, 32'h0040_0000));
    cmd(6'h0d, rca_arg, 1'b0, sh(6'h0d, `CS_S_TRAN, 32'h0));
    cmd(6'h0d, rca_arg, 1'b1, 144'h0);
    `CHK(irq, 1'b1)
    rd(`CS_INT_STATUS, {2'b00, 32'h0000_001f});
    wr(`CS_INT_STATUS, 32'h0000_001f, 2'b00);
    rd(`CS_INT_STATUS, {2'b00, 32'h0});
    `CHK(irq, 1'b0)
    // status polling picks up the flag of the failed frame
    cmd(6'h0d, rca_arg, 1'b0, sh(6'h0d, `CS_S_TRAN, 32'h0080_0000));
    cmd(6'h0d, rca_arg, 1'b0, sh(6'h0d, `CS_S_TRAN, 32'h0));
    wr(`CS_INJECT, 32'h8000_0000, 2'b00);
    cmd(6'h0d, rca_arg, 1'b0, sh(6'h0d, `CS_S_TRAN, 32'h8000_0000));
    cmd(6'h0d, rca_arg, 1'b0, sh(6'h0d, `CS_S_TRAN, 32'h0));
    cmd(6'h07, 32'h5555_0000, 1'b0, sh(6'h07, `CS_S_TRAN, 32'h0));
    rd(`CS_STATE, {2'b00, 32'h1234_0003});
    cmd(6'h00, 32'h0, 1'b0, 144'h0);
    cmd(6'h0d, rca_arg, 1'b0, 144'h0);
    complete_run();
  end
endmodule
